// [design/ssp_pkg.sv]
package ssp_pkg;
	// ----------------------------------------------------------------
	// Word sizes
	// ----------------------------------------------------------------
	localparam int SR_W        = 24;    // Serial shift register width
	localparam int FREQ_W      = 22;    // Each frequency word
	localparam int REF_W       = 16;    // Reference word
	localparam int ADDR_W      = 2;     // Trailing buffer address bits
	localparam int A_W         = 4;     // A counter field
	localparam int M_W         = 15;    // M counter field
	localparam int RATIO_W     = 13;    // Reference divider ratio
	localparam int UA_W        = 8;     // Pump one current, microamps
	localparam int MULT_W      = 4;     // Pump two multiplier, times two

	// ----------------------------------------------------------------
	// Frequency word field positions
	// ----------------------------------------------------------------
	localparam int FW_A_LSB    = 0;
	localparam int FW_M_LSB    = 4;
	localparam int FW_SENSE    = 19;
	localparam int FW_GAIN_LO  = 20;
	localparam int FW_GAIN_HI  = 21;

	// ----------------------------------------------------------------
	// Reference word field positions
	// ----------------------------------------------------------------
	localparam int RW_CTL_LO   = 0;
	localparam int RW_CTL_HI   = 1;
	localparam int RW_PRESC    = 2;
	localparam int RW_RATIO_LSB = 3;

	// ----------------------------------------------------------------
	// Default buffer address codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] CODE_F1_DEF  = 2'h0;
	localparam logic [1:0] CODE_F2_DEF  = 2'h1;
	localparam logic [1:0] CODE_ACT_DEF = 2'h2;
	localparam logic [1:0] CODE_REF_DEF = 2'h3;
	localparam logic [SR_W-1:0]   SR_RST   = 24'h000000;
	localparam logic [FREQ_W-1:0] FREQ_RST = 22'h000000;
	localparam logic [REF_W-1:0]  REF_RST  = 16'h0000;

	// ----------------------------------------------------------------
	// Pump one currents in microamps and pump two multipliers x2,
	// indexed by {gain_sel_lo, gain_sel_hi}
	// ----------------------------------------------------------------
	localparam logic [UA_W-1:0]   UA_00 = 8'h32;   // 50
	localparam logic [UA_W-1:0]   UA_HI = 8'h4B;   // 75
	localparam logic [UA_W-1:0]   UA_LO = 8'h7D;   // 125
	localparam logic [UA_W-1:0]   UA_11 = 8'hC8;   // 200
	localparam logic [MULT_W-1:0] MX_00 = 4'h2;    // 1
	localparam logic [MULT_W-1:0] MX_HI = 4'h3;    // 1.5
	localparam logic [MULT_W-1:0] MX_LO = 4'h5;    // 2.5
	localparam logic [MULT_W-1:0] MX_11 = 4'h8;    // 4

	// ----------------------------------------------------------------
	// Pin vector indices for the input synchroniser
	// ----------------------------------------------------------------
	localparam int PIN_N     = 6;
	localparam int PIN_DATA  = 0;
	localparam int PIN_SCLK  = 1;
	localparam int PIN_CE    = 2;
	localparam int PIN_SEL   = 3;
	localparam int PIN_PD    = 4;
	localparam int PIN_LOCK  = 5;
endpackage : ssp_pkg

// [design/ssp_top.sv]
`timescale 1ns/1ps
// Behaviour
// R1: Three-wire link fills a 24-bit shift register
// R2: Most significant bit arrives first
// R3: Chip enable fall copies word to addressed buffer
// R4: Two 22-bit frequency words: A/M, gain, sense
// R5: Select high picks word one, low word two
// R6: 16-bit reference: ratio, enables, prescaler select
// R7: Active-A code updates only A field
// R8: Shifting never disturbs loaded buffers
// R9: Inactive frequency word reloadable while other runs
// R10: Controller sends 24 or 18 bit frames; the bench also sends a 6-bit active-A frame
// R11: Controller zeroes unused A bit in 8/9
// R12: Loading continues during power down
// R13: Gain bits pick pump one current
// R14: Gain bits pick pump two multiplier
// R15: Sense bit sets polarity and swaps detector
// R16: Enable bits decode outputs and pump one
// R17: Lock indicator low in lock; gates pump
// R18: Prescaler bit picks 16/17 or 8/9
// R19: Buffer address codes are parameters
// R20: Data sampled on serial clock rise, enable high
module ssp_top
	import ssp_pkg::*;
#(
	parameter logic [1:0] CODE_F1  = CODE_F1_DEF,
	parameter logic [1:0] CODE_F2  = CODE_F2_DEF,
	parameter logic [1:0] CODE_ACT = CODE_ACT_DEF,
	parameter logic [1:0] CODE_REF = CODE_REF_DEF
) (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               srst,
	// Serial link pins
	input  wire logic               ser_data,
	input  wire logic               ser_clk,
	input  wire logic               chip_en,
	// Control pins
	input  wire logic               freq_sel,
	input  wire logic               power_down,
	input  wire logic               lock_det,
	// Active divider settings
	output logic [A_W-1:0]          a_count,
	output logic [M_W-1:0]          m_count,
	output logic [RATIO_W-1:0]      ref_ratio,
	output logic                    presc_eight_nine,
	// Phase detector settings
	output logic                    gain_sel_lo,
	output logic                    gain_sel_hi,
	output logic                    pump_sink,
	output logic                    det_swap,
	output logic [UA_W-1:0]         pump_one_ua,
	output logic [MULT_W-1:0]       pump_two_mult_x2,
	// Enables and lock indicator
	output logic                    out_pump_ctl_lo,
	output logic                    out_pump_ctl_hi,
	output logic                    div_out_en,
	output logic                    pump_one_en,
	output logic                    pump_two_en,
	output logic                    lock_ind_n
);

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	logic [PIN_N-1:0] pin_s1_reg;     // First stage, read by second only
	logic [PIN_N-1:0] pin_s2_reg;     // Second stage
	logic [PIN_N-1:0] pin_s3_reg;     // Third stage
	logic [PIN_N-1:0] pin_lvl_reg;    // Accepted level
	logic [PIN_N-1:0] pin_lvl_next;
	logic [PIN_N-1:0] pins;

	assign pins = {lock_det, power_down, freq_sel, chip_en, ser_clk, ser_data};

	// A level is accepted only once two late stages agree, so a
	// glitch shorter than a clock cycle never becomes an edge
	always_comb begin
		for (int i = 0; i < PIN_N; i++) begin
			pin_lvl_next[i] = (pin_s2_reg[i] == pin_s3_reg[i]) ? pin_s3_reg[i]
			                                                  : pin_lvl_reg[i];
		end
	end

	// Stage registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_s1_reg  <= '0;
			pin_s2_reg  <= '0;
			pin_s3_reg  <= '0;
			pin_lvl_reg <= '0;
		end else begin
			pin_s1_reg  <= pins;
			pin_s2_reg  <= pin_s1_reg;
			pin_s3_reg  <= pin_s2_reg;
			pin_lvl_reg <= pin_lvl_next;
		end
	end

	// ----------------------------------------------------------------
	// Edge detection on the accepted levels
	// ----------------------------------------------------------------
	logic sclk_rise;   // Serial clock rising edge
	logic ce_fall;     // Chip enable falling edge
	logic ce_lvl;      // Chip enable level

	assign sclk_rise = pin_lvl_next[PIN_SCLK] & ~pin_lvl_reg[PIN_SCLK];
	assign ce_fall   = ~pin_lvl_next[PIN_CE] & pin_lvl_reg[PIN_CE];
	assign ce_lvl    = pin_lvl_reg[PIN_CE];

	// ----------------------------------------------------------------
	// Shift register and buffers
	// ----------------------------------------------------------------
	logic [SR_W-1:0]   shift_register_reg;
	logic [SR_W-1:0]   shift_register_next;
	logic [FREQ_W-1:0] freq_word_one_reg;
	logic [FREQ_W-1:0] freq_word_one_next;
	logic [FREQ_W-1:0] freq_word_two_reg;
	logic [FREQ_W-1:0] freq_word_two_next;
	logic [REF_W-1:0]  reference_word_reg;
	logic [REF_W-1:0]  reference_word_next;
	logic [ADDR_W-1:0] code;          // Last two bits shifted in
	logic [FREQ_W-1:0] new_freq;      // Word above the address bits
	logic [A_W-1:0]    new_a;         // A field of the incoming word
	logic              use_one;       // Word one is in control

	assign code     = shift_register_reg[ADDR_W-1:0];
	assign new_freq = shift_register_reg[SR_W-1:ADDR_W];
	assign new_a    = new_freq[FW_A_LSB +: A_W];
	assign use_one  = pin_lvl_reg[PIN_SEL];

	// R12: no power-down term, so loading never sleeps
	always_comb begin
		shift_register_next = shift_register_reg;
		freq_word_one_next  = freq_word_one_reg;
		freq_word_two_next  = freq_word_two_reg;
		reference_word_next = reference_word_reg;
		// R20: rising clock, enable high
		if (sclk_rise && ce_lvl) begin
			// R1 R2: shift in, MSB first
			shift_register_next = {shift_register_reg[SR_W-2:0], pin_lvl_reg[PIN_DATA]};
		end
		// R3: transfer on enable fall
		if (ce_fall) begin
			// R9 R19: either word, parameter codes
			if (code == CODE_F1) begin
				freq_word_one_next = new_freq;
			end else if (code == CODE_F2) begin
				freq_word_two_next = new_freq;
			end else if (code == CODE_REF) begin
				// Reference frame is 18 bits, so its word sits low
				reference_word_next = shift_register_reg[ADDR_W +: REF_W];
			end else if (code == CODE_ACT) begin
				// R7: only the A field moves
				if (use_one) begin
					freq_word_one_next[FW_A_LSB +: A_W] = new_a;
				end else begin
					freq_word_two_next[FW_A_LSB +: A_W] = new_a;
				end
			end
		end
	end

	// R8: buffers move only on transfer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shift_register_reg <= SR_RST;
			freq_word_one_reg  <= FREQ_RST;
			freq_word_two_reg  <= FREQ_RST;
			reference_word_reg <= REF_RST;
		end else begin
			shift_register_reg <= shift_register_next;
			freq_word_one_reg  <= freq_word_one_next;
			freq_word_two_reg  <= freq_word_two_next;
			reference_word_reg <= reference_word_next;
		end
	end

	// ----------------------------------------------------------------
	// Output decode
	// ----------------------------------------------------------------
	logic [FREQ_W-1:0] act;           // Word in control
	logic [1:0]        gain;          // {lo, hi} table index
	logic              ctl_lo;
	logic              ctl_hi;
	logic              in_lock;
	logic              pd;
	// Registered output set
	logic [A_W-1:0]     a_count_next;
	logic [UA_W-1:0]    ua_next;
	logic [MULT_W-1:0]  mx_next;
	logic               pump_one_next;

	assign in_lock = pin_lvl_reg[PIN_LOCK];
	assign pd      = pin_lvl_reg[PIN_PD];
	assign ctl_lo  = reference_word_reg[RW_CTL_LO];
	assign ctl_hi  = reference_word_reg[RW_CTL_HI];
	// R4 R5: select picks 22-bit word
	assign act     = use_one ? freq_word_one_reg : freq_word_two_reg;
	assign gain    = {act[FW_GAIN_LO], act[FW_GAIN_HI]};

	// Current tables and enable decode
	always_comb begin
		// R18: 8/9 uses three A bits
		a_count_next = act[FW_A_LSB +: A_W];
		if (reference_word_reg[RW_PRESC]) begin
			a_count_next[A_W-1] = 1'b0;
		end
		// R13: pump one current, R14: pump two multiplier
		case (gain)
			2'h0: begin
				ua_next = UA_00;
				mx_next = MX_00;
			end
			2'h1: begin
				ua_next = UA_HI;
				mx_next = MX_HI;
			end
			2'h2: begin
				ua_next = UA_LO;
				mx_next = MX_LO;
			end
			default: begin
				ua_next = UA_11;
				mx_next = MX_11;
			end
		endcase
		// R16: enable code decode, R17: lock gating
		case ({ctl_hi, ctl_lo})
			2'h0:    pump_one_next = 1'b1;
			2'h1:    pump_one_next = 1'b0;
			default: pump_one_next = ~in_lock;
		endcase
		// Power down stops the analog side, never the storage
		if (pd) begin
			pump_one_next = 1'b0;
		end
	end

	// Output registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			a_count          <= '0;
			m_count          <= '0;
			ref_ratio        <= '0;
			presc_eight_nine <= 1'b0;
			gain_sel_lo      <= 1'b0;
			gain_sel_hi      <= 1'b0;
			pump_sink        <= 1'b0;
			det_swap         <= 1'b0;
			pump_one_ua      <= UA_00;
			pump_two_mult_x2 <= MX_00;
			out_pump_ctl_lo  <= 1'b0;
			out_pump_ctl_hi  <= 1'b0;
			div_out_en       <= 1'b0;
			pump_one_en      <= 1'b0;
			pump_two_en      <= 1'b0;
			lock_ind_n       <= 1'b1;
		end else begin
			a_count          <= a_count_next;
			m_count          <= act[FW_M_LSB +: M_W];
			// R6: reference fields
			ref_ratio        <= reference_word_reg[RW_RATIO_LSB +: RATIO_W];
			presc_eight_nine <= reference_word_reg[RW_PRESC];
			gain_sel_lo      <= act[FW_GAIN_LO];
			gain_sel_hi      <= act[FW_GAIN_HI];
			// R15: sense sets sink and swap
			pump_sink        <= act[FW_SENSE];
			det_swap         <= act[FW_SENSE];
			pump_one_ua      <= ua_next;
			pump_two_mult_x2 <= mx_next;
			out_pump_ctl_lo  <= ctl_lo;
			out_pump_ctl_hi  <= ctl_hi;
			div_out_en       <= ctl_lo & ~pd;
			pump_one_en      <= pump_one_next;
			pump_two_en      <= ~pd;
			// R17: low while locked
			lock_ind_n       <= ~in_lock;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_shift;
		@(posedge ref_clk) disable iff (srst)
		(sclk_rise && ce_lvl) |=> shift_register_reg ==
			{$past(shift_register_reg[SR_W-2:0]), $past(pin_lvl_reg[PIN_DATA])};
	endproperty
	a_shift: assert property (p_shift) else $error("shift order wrong"); // R2
	property p_no_shift;
		@(posedge ref_clk) disable iff (srst)
		!ce_lvl |=> $stable(shift_register_reg);
	endproperty
	a_no_shift: assert property (p_no_shift) else $error("shift while idle"); // R20
	property p_load_one;
		@(posedge ref_clk) disable iff (srst)
		(ce_fall && code == CODE_F1) |=> freq_word_one_reg == $past(new_freq);
	endproperty
	a_load_one: assert property (p_load_one) else $error("word one not loaded"); // R3
	property p_hold;
		@(posedge ref_clk) disable iff (srst)
		!ce_fall |=> $stable(freq_word_one_reg) && $stable(freq_word_two_reg)
			&& $stable(reference_word_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("buffer disturbed"); // R8
	property p_act_a;
		@(posedge ref_clk) disable iff (srst)
		(ce_fall && code == CODE_ACT && !use_one) |=>
			freq_word_two_reg[FREQ_W-1:A_W] == $past(freq_word_two_reg[FREQ_W-1:A_W])
			&& freq_word_two_reg[A_W-1:0] == $past(new_a) && $stable(freq_word_one_reg);
	endproperty
	a_act_a: assert property (p_act_a) else $error("active A transfer wrong"); // R7
	property p_select;
		@(posedge ref_clk) disable iff (srst)
		use_one ##1 use_one |-> m_count == $past(freq_word_one_reg[FW_M_LSB +: M_W]);
	endproperty
	a_select: assert property (p_select) else $error("wrong word in control"); // R5
	property p_gain;
		@(posedge ref_clk) disable iff (srst)
		(gain == 2'h2) |=> pump_one_ua == UA_LO && pump_two_mult_x2 == MX_LO;
	endproperty
	a_gain: assert property (p_gain) else $error("gain table wrong"); // R13
	property p_gate;
		@(posedge ref_clk) disable iff (srst)
		(ctl_hi && in_lock) |=> !pump_one_en && !lock_ind_n;
	endproperty
	a_gate: assert property (p_gate) else $error("lock gating wrong"); // R17
	property p_ctl;
		@(posedge ref_clk) disable iff (srst)
		(!pd && !ctl_hi && !ctl_lo) |=> pump_one_en && !div_out_en && pump_two_en;
	endproperty
	a_ctl: assert property (p_ctl) else $error("enable decode wrong"); // R16
	property p_pd_load;
		@(posedge ref_clk) disable iff (srst)
		(pd && ce_fall && code == CODE_F1) |=> freq_word_one_reg == $past(new_freq);
	endproperty
	a_pd_load: assert property (p_pd_load) else $error("load lost in power down"); // R12

endmodule : ssp_top

// [bench/ssp_ctl_model.sv]
`timescale 1ns/1ps
module ssp_ctl_model
	import ssp_pkg::*;
(
	// Serial link pins
	output logic ser_data,
	output logic ser_clk,
	output logic chip_en
);
	// ----------------------------------------------------------------
	// Idle link
	// ----------------------------------------------------------------
	// Serial clock stands low outside frames
	initial begin
		ser_data = 1'b0;
		ser_clk  = 1'b0;
		chip_en  = 1'b0;
	end

	// ----------------------------------------------------------------
	// Frame sender
	// ----------------------------------------------------------------
	// frame of n bits, caller picks the length and zero bits
	task automatic send(input logic [SR_W-1:0] word, input int n, input bit keep);
		// Offset keeps link edges off the ref_clk edges
		#3;
		chip_en = 1'b1;
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			ser_data = word[i];
			#40;
			ser_clk = 1'b1;
			#40;
			ser_clk = 1'b0;
		end
		// Released data line shows the inverse of its last bit
		ser_data = ~ser_data;
		if (!keep) begin
			#40;
			chip_en = 1'b0;
		end
	endtask : send

	// Closes a frame left open by send
	task automatic close();
		#40;
		chip_en = 1'b0;
	endtask : close
endmodule : ssp_ctl_model

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench
	import ssp_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                ref_clk, srst, ser_data, ser_clk, chip_en;
	logic                freq_sel, power_down, lock_det, presc_eight_nine;
	logic [A_W-1:0]      a_count;
	logic [M_W-1:0]      m_count;
	logic [RATIO_W-1:0]  ref_ratio;
	logic                gain_sel_lo, gain_sel_hi, pump_sink, det_swap;
	logic [UA_W-1:0]     pump_one_ua;
	logic [MULT_W-1:0]   pump_two_mult_x2;
	logic                out_pump_ctl_lo, out_pump_ctl_hi, div_out_en;
	logic                pump_one_en, pump_two_en, lock_ind_n;
	int                  fail_count = 0;   // Mismatches seen
	int                  n_tests = 0;      // Comparisons made
	// Expected pump settings indexed by {lo, hi}
	localparam logic [UA_W-1:0]   UA_T [4] = '{UA_00, UA_HI, UA_LO, UA_11};
	localparam logic [MULT_W-1:0] MX_T [4] = '{MX_00, MX_HI, MX_LO, MX_11};
	localparam logic [FREQ_W-1:0] W1 = 22'h2B5A69;
	localparam logic [FREQ_W-1:0] W2 = 22'h15A596;
	localparam logic [FREQ_W-1:0] W3 = 22'h0C3F1E;

	ssp_top ssp_top_i (.ref_clk(ref_clk), .srst(srst), .ser_data(ser_data),
		.ser_clk(ser_clk), .chip_en(chip_en), .freq_sel(freq_sel),
		.power_down(power_down), .lock_det(lock_det), .a_count(a_count),
		.m_count(m_count), .ref_ratio(ref_ratio), .presc_eight_nine(presc_eight_nine),
		.gain_sel_lo(gain_sel_lo), .gain_sel_hi(gain_sel_hi), .pump_sink(pump_sink),
		.det_swap(det_swap), .pump_one_ua(pump_one_ua), .pump_two_mult_x2(pump_two_mult_x2),
		.out_pump_ctl_lo(out_pump_ctl_lo), .out_pump_ctl_hi(out_pump_ctl_hi),
		.div_out_en(div_out_en), .pump_one_en(pump_one_en), .pump_two_en(pump_two_en),
		.lock_ind_n(lock_ind_n));
	ssp_ctl_model ssp_ctl_model_i (.ser_data(ser_data), .ser_clk(ser_clk), .chip_en(chip_en));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	// Vector compare, zero extended
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk

	// One frame, then time for sync, buffer and output stages
	task automatic load(input logic [1:0] code, input logic [21:0] w, input int n);
		@(negedge ref_clk);
		ssp_ctl_model_i.send({w, code}, n, 1'b0);
		repeat (12) @(negedge ref_clk);
	endtask : load

	task automatic sel(input logic v);
		freq_sel = v;
		repeat (8) @(negedge ref_clk);
	endtask : sel

	// Active frequency fields against a stored word
	task automatic chk_fw(input logic [FREQ_W-1:0] w);
		chk(a_count, w[3:0]);
		chk(m_count, w[18:4]);
		chk(pump_sink, w[19]);
		chk(det_swap, w[19]);
		chk(gain_sel_lo, w[20]);
		chk(gain_sel_hi, w[21]);
	endtask : chk_fw

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk(pump_one_ua, UA_00);
		chk(pump_two_mult_x2, MX_00);
		chk(lock_ind_n, 1'b1);
		srst = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(pump_one_en, 1'b1);
		chk(pump_two_en, 1'b1);
		$display("test reset done");
	endtask : t_reset

	// Both words loaded, select pin picks between them
	task automatic t_freq();
		load(CODE_F1_DEF, W1, 24);
		load(CODE_F2_DEF, W2, 24);
		sel(1'b1);
		chk_fw(W1);
		sel(1'b0);
		chk_fw(W2);
		$display("test freq done");
	endtask : t_freq

	// Active-A lands in word two only, then word two reloads behind word one
	task automatic t_act();
		load(CODE_ACT_DEF, 22'h000007, 6);
		chk(a_count, 4'h7);
		chk(m_count, W2[18:4]);
		sel(1'b1);
		chk_fw(W1);
		@(negedge ref_clk);
		ssp_ctl_model_i.send({W3, CODE_F2_DEF}, 24, 1'b1);
		repeat (12) @(negedge ref_clk);
		chk_fw(W1);
		ssp_ctl_model_i.close();
		repeat (12) @(negedge ref_clk);
		chk_fw(W1);
		sel(1'b0);
		chk_fw(W3);
		$display("test active done");
	endtask : t_act

	// Every gain code
	task automatic t_gain();
		sel(1'b1);
		for (int k = 0; k < 4; k++) begin
			load(CODE_F1_DEF, {k[0], k[1], 20'h00001}, 24);
			chk(pump_one_ua, UA_T[k]);
			chk(pump_two_mult_x2, MX_T[k]);
		end
		$display("test gain done");
	endtask : t_gain

	// Every enable code, in and out of lock
	task automatic t_ref();
		logic [1:0] c;
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			load(CODE_REF_DEF, {6'h00, 13'h1234, 1'b0, c}, 18);
			chk(ref_ratio, 13'h1234);
			chk(out_pump_ctl_lo, c[0]);
			chk(out_pump_ctl_hi, c[1]);
			for (int l = 0; l < 2; l++) begin
				lock_det = l[0];
				repeat (8) @(negedge ref_clk);
				chk(div_out_en, c[0]);
				chk(pump_one_en, c[1] ? !l[0] : !c[0]);
				chk(pump_two_en, 1'b1);
				chk(lock_ind_n, !l[0]);
			end
		end
		lock_det = 1'b0;
		$display("test ref done");
	endtask : t_ref

	// Loading in power down, eight-nine prescaler select with the unused A bit sent as zero
	task automatic t_pd();
		power_down = 1'b1;
		load(CODE_REF_DEF, {6'h00, 13'h0FFF, 1'b1, 2'h1}, 18);
		// unused A bit sent as zero
		load(CODE_F1_DEF, 22'h000157, 24);
		chk(presc_eight_nine, 1'b1);
		chk(a_count, 4'h7);
		chk(m_count, 15'h0015);
		chk(div_out_en, 1'b0);
		chk(pump_two_en, 1'b0);
		power_down = 1'b0;
		repeat (8) @(negedge ref_clk);
		chk(div_out_en, 1'b1);
		chk(pump_two_en, 1'b1);
		$display("test power down done");
	endtask : t_pd

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		freq_sel = 1'b0;
		power_down = 1'b0;
		lock_det = 1'b0;
		repeat (5) @(negedge ref_clk);
		t_reset();
		t_freq();
		t_act();
		t_gain();
		t_ref();
		t_pd();
		stop_test();
	end

	// A hang counts as a mismatch
	initial begin
		#500000;
		fail_count++;
		stop_test();
	end
endmodule : testbench
